/* File: i2c_master_baud_arb.sv */
// two-wire bus master: baud counter, bus condition detect, arbitration, registers
// Behaviour
// - master accepts start, restart, transmit, stop, receive and acknowledge requests.
// - master alone drives clock pulses and start and stop conditions.
// - transfers end in stop or restart; restart keeps the bus owned.
// - no queueing; buffer write during a start is dropped, collision flagged.
// - start and stop seen bits clear on reset and while disabled.
// - stop detected on a busy bus raises the port interrupt.
// - sampled data line differing from driven level sets bus collision.
// - arbitration checked in address, data, start, restart and acknowledge.
// - clock half period is reload plus one, times two clocks.
// - reload value comes from the low seven bits of the baud register.
// - baud counter counts down to zero and holds until reloaded.
// - baud counter decrements twice per instruction cycle, in Q2 and Q4.
// - reload on any request, otherwise only when the master holds the clock low or the clock line is sampled high.
// - enable bit 3 gates the bus collision interrupt.
// - enable bit 7 gates low voltage interrupt; other bits read zero.
`default_nettype none
`include "i2c_master_params.svh"
module i2c_master_baud_arb #(
    parameter int BAUD_W = 7
) (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       low_voltage_i,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_o,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic            irq_o
);
    import i2c_master_pkg::*;

    // the reload field must fit inside the register byte
    if (BAUD_W < 1 || BAUD_W > 7) begin : g_bad_width
        $error("BAUD_W must lie between 1 and 7");
    end

    mst_state_t        state_q;
    xfer_kind_t        kind_q;
    logic [3:0]        n_q;
    logic [7:0]        sh_q;
    logic [7:0]        rx_buf_q;
    logic [7:0]        irq_st_q;
    logic [BAUD_W-1:0] baud_q;
    logic [BAUD_W-1:0] brg_q;
    logic [1:0]        qph_q;
    logic [2:0]        scl_s_q;
    logic [2:0]        sda_s_q;
    logic [3:0]        mode_q;
    logic [8:0]        half_cnt_q;
    logic              scl_f_q, sda_f_q, scl_prev_q, sda_prev_q;
    logic              en_q, port_ie_q, write_collision_flag_q, bus_collision_irq_enable_q, lvie_q, ack_data_q;
    logic              ack_in_q, rx_full_q, start_seen_q, stop_seen_q;
    logic              scl_oe_q, sda_oe_q;
    logic              master_on, wr_cmd, wr_buf, tick, brg_reload, brg_step;
    logic              go_start, go_rs, go_stop, go_rx, go_ack, go_tx, go_any;
    logic              start_det, stop_det, chk_drive, bcl_hit, sda_pull;
    logic              last_bit, done_ev, rx_done, port_ev;
    logic [7:0]        irq_set, irq_clr, irq_mask;

    default clocking dcb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // request decode; a request outside its bus state is ignored
    assign master_on = en_q && (mode_q == `MODE_MASTER);
    assign wr_cmd    = reg_wr_i && (reg_addr_i == `OFS_CMD) && master_on;
    assign wr_buf    = reg_wr_i && (reg_addr_i == `OFS_BUF);
    assign go_start  = wr_cmd && reg_wdata_i[`CMD_START] && (state_q == st_idle);
    assign go_rs     = wr_cmd && reg_wdata_i[`CMD_RESTART] && (state_q == st_hold);
    assign go_stop   = wr_cmd && reg_wdata_i[`CMD_STOP] && (state_q == st_hold) && !go_rs;
    assign go_rx     = wr_cmd && reg_wdata_i[`CMD_RX] && (state_q == st_hold)
                       && !go_rs && !go_stop;
    assign go_ack    = wr_cmd && reg_wdata_i[`CMD_ACK] && (state_q == st_hold)
                       && !go_rs && !go_stop && !go_rx;
    assign go_tx     = wr_buf && master_on && (state_q == st_hold);
    assign go_any    = go_start || go_rs || go_stop || go_rx || go_ack || go_tx;

    // three-stage sample; a change counts once stages two and three agree
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scl_s_q    <= 3'h7;
            sda_s_q    <= 3'h7;
            scl_f_q    <= 1'b1;
            sda_f_q    <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_s_q    <= {scl_s_q[1:0], scl_i};
            sda_s_q    <= {sda_s_q[1:0], sda_i};
            if (scl_s_q[1] == scl_s_q[2]) begin
                scl_f_q <= scl_s_q[2];
            end
            if (sda_s_q[1] == sda_s_q[2]) begin
                sda_f_q <= sda_s_q[2];
            end
            scl_prev_q <= scl_f_q;
            sda_prev_q <= sda_f_q;
        end
    end

    // data edges while the clock stays high mark start and stop
    assign start_det = scl_f_q && scl_prev_q && sda_prev_q && !sda_f_q;
    assign stop_det  = scl_f_q && scl_prev_q && !sda_prev_q && sda_f_q;

    // four quarter phases per instruction cycle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            qph_q <= 2'h0;
        end else begin
            qph_q <= qph_q + 2'h1;
        end
    end

    // counter steps only in Q2 and Q4
    assign tick = (qph_q == `Q2_PH) || (qph_q == `Q4_PH);
    // reload plus one ticks per half
    // a stretched clock holds off the reload
    assign brg_reload = tick && (brg_q == '0) && (scl_oe_q || scl_f_q);
    assign brg_step   = brg_reload && (state_q != st_idle) && (state_q != st_hold);

    // reload field is the low bits of the baud register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            baud_q <= '0;
        end else if (reg_wr_i && reg_addr_i == `OFS_BAUD) begin
            baud_q <= reg_wdata_i[BAUD_W-1:0];
        end
    end

    // count down, then rest at zero until reloaded
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            brg_q <= '0;
        end else if (go_any || brg_reload) begin
            brg_q <= baud_q;
        end else if (tick && brg_q != '0) begin
            brg_q <= brg_q - 1'b1;
        end
    end

    // compare only where we own the data line level
    assign chk_drive = (state_q == st_start_a) || ((state_q == st_high)
                       && (kind_q == k_ack || (kind_q == k_tx && n_q < `BIT_ACK)));
    // released line read low means another master won
    assign bcl_hit   = chk_drive && scl_f_q && !sda_oe_q && !sda_f_q;

    // data line enable wanted for the bit now in the low phase
    always_comb begin
        sda_pull = 1'b0;
        last_bit = 1'b1;
        unique case (kind_q)
            k_tx: begin
                sda_pull = (n_q < `BIT_ACK) && !sh_q[7];
                last_bit = (n_q == `BIT_ACK);
            end
            k_rx: last_bit = (n_q == `BIT_LAST);
            k_ack: sda_pull = !ack_data_q;
            default: sda_pull = 1'b0;
        endcase
    end

    assign done_ev = brg_step && master_on && !bcl_hit && ((state_q == st_start_b)
                     || (state_q == st_stop_b) || (state_q == st_high && last_bit));
    assign rx_done = done_ev && (state_q == st_high) && (kind_q == k_rx);

    // bus sequencer; clock changes only on baud steps, or when disable or collision drops the bus
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q  <= st_idle;
            kind_q   <= k_tx;
            n_q      <= `BIT_FIRST;
            sh_q     <= `RST_BYTE;
            rx_buf_q <= `RST_BYTE;
            ack_in_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (!master_on || bcl_hit) begin
            // lose the bus cleanly, both lines let go
            state_q  <= st_idle;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            // every clock pulse and condition comes from here
            unique case (state_q)
                st_idle: if (go_start) begin
                    state_q <= st_start_a;
                end
                st_start_a: if (brg_step) begin
                    sda_oe_q <= 1'b1;
                    state_q  <= st_start_b;
                end
                st_start_b: if (brg_step) begin
                    scl_oe_q <= 1'b1;
                    state_q  <= st_hold;
                end
                st_hold: begin
                    n_q <= `BIT_FIRST;
                    if (go_tx) begin
                        sh_q    <= reg_wdata_i;
                        kind_q  <= k_tx;
                        state_q <= st_low;
                    end else if (go_rx) begin
                        kind_q  <= k_rx;
                        state_q <= st_low;
                    end else if (go_ack) begin
                        kind_q  <= k_ack;
                        state_q <= st_low;
                    end else if (go_stop) begin
                        sda_oe_q <= 1'b1;
                        state_q  <= st_stop_a;
                    end else if (go_rs) begin
                        // clock stays low, the bus stays ours
                        sda_oe_q <= 1'b0;
                        state_q  <= st_rs_a;
                    end
                end
                st_low: begin
                    // data moves a cycle after the clock went low
                    sda_oe_q <= sda_pull;
                    if (brg_step) begin
                        scl_oe_q <= 1'b0;
                        state_q  <= st_high;
                    end
                end
                st_high: if (brg_step) begin
                    scl_oe_q <= 1'b1;
                    n_q      <= n_q + 4'h1;
                    if (kind_q == k_tx && n_q == `BIT_ACK) begin
                        ack_in_q <= sda_f_q;
                    end else begin
                        sh_q <= {sh_q[6:0], sda_f_q};
                    end
                    if (kind_q == k_rx && last_bit) begin
                        rx_buf_q <= {sh_q[6:0], sda_f_q};
                    end
                    state_q <= last_bit ? st_hold : st_low;
                end
                st_rs_a: if (brg_step) begin
                    scl_oe_q <= 1'b0;
                    state_q  <= st_start_a;
                end
                st_stop_a: if (brg_step) begin
                    scl_oe_q <= 1'b0;
                    state_q  <= st_stop_b;
                end
                st_stop_b: if (brg_step) begin
                    sda_oe_q <= 1'b0;
                    state_q  <= st_idle;
                end
                default: state_q <= st_idle;
            endcase
        end
    end

    // control, enable and command registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_q     <= 4'h0;
            en_q       <= 1'b0;
            port_ie_q  <= 1'b0;
            bus_collision_irq_enable_q    <= 1'b0;
            lvie_q     <= 1'b0;
            ack_data_q <= 1'b0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `OFS_CTRL) begin
                mode_q    <= reg_wdata_i[`CTRL_MODE_LSB +: 4];
                en_q      <= reg_wdata_i[`CTRL_EN];
                port_ie_q <= reg_wdata_i[`CTRL_PIE];
            end
            // bus collision and low voltage enables, the rest unbuilt
            if (reg_addr_i == `OFS_IRQ_EN) begin
                bus_collision_irq_enable_q <= reg_wdata_i[`IRQ_BCL];
                lvie_q  <= reg_wdata_i[`IRQ_LV];
            end
            if (reg_addr_i == `OFS_CMD) begin
                ack_data_q <= reg_wdata_i[`CMD_ACKDT];
            end
        end
    end

    // status flags; a setting event beats a same-cycle clear, but a disabled port clears the seen bits over a detect
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            start_seen_q <= 1'b0;
            stop_seen_q  <= 1'b0;
            write_collision_flag_q       <= 1'b0;
            rx_full_q    <= 1'b0;
        end else begin
            // disabled port forgets the bus conditions
            if (!en_q) begin
                start_seen_q <= 1'b0;
                stop_seen_q  <= 1'b0;
            end else if (start_det) begin
                start_seen_q <= 1'b1;
                stop_seen_q  <= 1'b0;
            end else if (stop_det) begin
                start_seen_q <= 1'b0;
                stop_seen_q  <= 1'b1;
            end
            // no queue, the write is dropped and reported
            if (wr_buf && master_on && state_q != st_hold) begin
                write_collision_flag_q <= 1'b1;
            end else if (reg_wr_i && reg_addr_i == `OFS_CTRL && !reg_wdata_i[`CTRL_WRITE_COLLISION_FLAG]) begin
                write_collision_flag_q <= 1'b0;
            end
            if (rx_done) begin
                rx_full_q <= 1'b1;
            end else if (reg_rd_i && reg_addr_i == `OFS_BUF) begin
                rx_full_q <= 1'b0;
            end
        end
    end

    // a stop seen while the bus was busy is a port event
    assign port_ev  = done_ev || (stop_det && start_seen_q);
    assign irq_set  = {low_voltage_i, 3'h0, bcl_hit, 2'h0, port_ev};
    assign irq_clr  = (reg_wr_i && reg_addr_i == `OFS_IRQ_CLR) ? reg_wdata_i : 8'h00;
    assign irq_mask = {lvie_q, 3'h0, bus_collision_irq_enable_q, 2'h0, port_ie_q};

    // sticky events and the gated interrupt line
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_st_q <= 8'h00;
            irq_o    <= 1'b0;
        end else begin
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
            // collision reaches the line only when enabled
            irq_o    <= |(irq_st_q & irq_mask);
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `OFS_IRQ_STAT: reg_rdata_o <= irq_st_q;
                `OFS_IRQ_EN:   reg_rdata_o <= irq_mask & ~(8'h01 << `IRQ_PORT);
                `OFS_CTRL:     reg_rdata_o <= {write_collision_flag_q, port_ie_q, en_q, 1'b0, mode_q};
                `OFS_CMD:      reg_rdata_o <= 8'(ack_data_q) << `CMD_ACKDT;
                `OFS_BUF:      reg_rdata_o <= rx_buf_q;
                `OFS_BAUD:     reg_rdata_o <= 8'(baud_q);
                `OFS_STAT:     reg_rdata_o <= {3'h0, stop_seen_q, start_seen_q, ack_in_q,
                                               state_q != st_idle, rx_full_q};
                default:       reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // open drain: the level is always low, only the enables move
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end
    assign scl_oe_o = scl_oe_q;
    assign sda_oe_o = sda_oe_q;

    // clocks since the last baud step, only for checking
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            half_cnt_q <= 9'h000;
        end else if (brg_step) begin
            half_cnt_q <= 9'h000;
        end else begin
            half_cnt_q <= half_cnt_q + 9'h001;
        end
    end

    // a buffer write on an owned bus starts a byte
    tx_accept_a: assert property (
        go_tx |=> state_q == st_low && kind_q == k_tx && sh_q == $past(reg_wdata_i))
        else $error("buffer write did not start a byte");
    // start and stop drive data low under a released clock
    cond_shape_a: assert property (
        (state_q == st_start_b || state_q == st_stop_b) |-> sda_oe_q && !scl_oe_q)
        else $error("bad start or stop shape");
    // restart keeps the clock held low
    restart_hold_a: assert property (
        go_rs |=> state_q == st_rs_a && scl_oe_q && !sda_oe_q)
        else $error("restart released the bus");
    // write during a start is refused
    write_collision_flag_set_a: assert property (
        wr_buf && master_on && state_q == st_start_a |=> write_collision_flag_q && state_q != st_low)
        else $error("queued write not refused");
    // bus condition bits clear when disabled
    seen_clear_a: assert property (
        !en_q |=> !start_seen_q && !stop_seen_q)
        else $error("condition bits kept while disabled");
    // stop on a busy bus sets the port event
    stop_irq_a: assert property (
        stop_det && start_seen_q |=> irq_st_q[`IRQ_PORT])
        else $error("stop on busy bus not flagged");
    // collision drops both lines and flags
    bcl_release_a: assert property (
        bcl_hit |=> state_q == st_idle && !scl_oe_q && !sda_oe_q && irq_st_q[`IRQ_BCL])
        else $error("collision not handled");
    // lost arbitration during a start is caught
    arb_start_a: assert property (
        state_q == st_start_a && scl_f_q && !sda_f_q |=> state_q == st_idle)
        else $error("start arbitration unchecked");
    // steady half period of the clock
    clk_half_a: assert property (
        brg_step && state_q == st_low && n_q != `BIT_FIRST
        |-> half_cnt_q == 9'(2 * (baud_q + 1) - 1))
        else $error("half period wrong");
    // baud register write takes the low bits
    baud_load_a: assert property (
        reg_wr_i && reg_addr_i == `OFS_BAUD |=> baud_q == BAUD_W'($past(reg_wdata_i)))
        else $error("baud reload not stored");
    // counter rests at zero without a reload
    brg_rest_a: assert property (
        brg_q == '0 && !go_any && !brg_reload |=> brg_q == '0)
        else $error("counter left zero on its own");
    // no change outside Q2 and Q4
    brg_phase_a: assert property (
        !tick && !go_any |=> $stable(brg_q))
        else $error("counter moved off phase");
    // stretched clock holds the high phase
    stretch_wait_a: assert property (
        state_q == st_high && !scl_f_q && !reg_wr_i |=> state_q == st_high)
        else $error("clock stretch ignored");
    bcl_irq_a: assert property (
        irq_st_q[`IRQ_BCL] && bus_collision_irq_enable_q |=> irq_o)
        else $error("collision interrupt missing");
    // unbuilt enable bits read as zero
    pie_read_a: assert property (
        reg_rd_i && reg_addr_i == `OFS_IRQ_EN
        |=> (reg_rdata_o & 8'h77) == 8'h00 && reg_rdata_o[`IRQ_LV] == $past(lvie_q))
        else $error("enable register read wrong");
endmodule
`default_nettype wire

/* File: i2c_master_params.svh */
// offsets, field positions and timing constants of the two-wire master
`ifndef I2C_MASTER_PARAMS_SVH
`define I2C_MASTER_PARAMS_SVH
// register offsets
`define OFS_IRQ_STAT 8'h0d
`define OFS_IRQ_CLR  8'h0e
`define OFS_BUF      8'h13
`define OFS_CTRL     8'h14
`define OFS_IRQ_EN   8'h8d
`define OFS_CMD      8'h91
`define OFS_BAUD     8'h93
`define OFS_STAT     8'h94
// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_EN       5
`define CTRL_PIE      6
`define CTRL_WRITE_COLLISION_FLAG     7
`define MODE_MASTER   4'h8
// command register fields
`define CMD_START   0
`define CMD_RESTART 1
`define CMD_STOP    2
`define CMD_RX      3
`define CMD_ACK     4
`define CMD_ACKDT   5
// interrupt status, clear and enable fields
`define IRQ_PORT 0
`define IRQ_BCL  3
`define IRQ_LV   7
// status register fields
`define STAT_RXF   0
`define STAT_ACT   1
`define STAT_NACK  2
`define STAT_START 3
`define STAT_STOP  4
// quarter phases that step the baud counter
`define Q2_PH 2'h1
`define Q4_PH 2'h3
// bit indices within a byte transfer
`define BIT_FIRST 4'h0
`define BIT_LAST  4'h7
`define BIT_ACK   4'h8
`define RST_BYTE  8'h00
`endif

/* File: i2c_master_pkg.sv */
// state and transfer-kind types of the two-wire master
`default_nettype none
package i2c_master_pkg;
    typedef enum logic [3:0] {
        st_idle, st_start_a, st_start_b, st_hold, st_low, st_high,
        st_rs_a, st_stop_a, st_stop_b
    } mst_state_t;
    typedef enum logic [1:0] {k_tx, k_rx, k_ack} xfer_kind_t;
endpackage
`default_nettype wire

/* File: i2c_slave_model.sv */
// slave partner on the two-wire bus: acks bytes, captures them, stretches, collides
`default_nettype none
module i2c_slave_model (
    input  wire logic       clk_i,
    input  wire logic       scl_w_i,
    input  wire logic       sda_w_i,
    input  wire logic       stretch_i,
    input  wire logic       collide_i,
    output logic            scl_oe_o,
    output logic            sda_oe_o,
    output logic            got_o,
    output logic      [7:0] byte_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q = 4'h0;
    logic [7:0] sh_q  = 8'h00;
    logic       scl_q = 1'b1;
    logic       sda_q = 1'b1;
    logic       ack_q = 1'b0;
    // start resets the bit count; rising clock shifts data in msb first
    always @(posedge clk_i) begin
        scl_q <= scl_w_i;
        sda_q <= sda_w_i;
        got_o <= 1'b0;
        if (scl_w_i && scl_q && sda_q && !sda_w_i) begin
            cnt_q <= 4'h0;
        end else if (scl_w_i && !scl_q) begin
            cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
            sh_q  <= {sh_q[6:0], sda_w_i};
            got_o <= (cnt_q == 4'h7);
        end
        // ack low from the fall after bit 8 until the next fall
        if (!scl_w_i && scl_q) begin
            ack_q <= (cnt_q == 4'h8);
        end
        // hold clock low only once it has fallen, never pull it mid-high
        scl_oe_o <= stretch_i && (scl_oe_o || !scl_w_i);
    end
    assign byte_o   = sh_q;
    assign sda_oe_o = ack_q | collide_i; // collide is commanded by the bench only
endmodule
`default_nettype wire

/* File: i2c_master_baud_and_arbitration_tb.sv */
// self-checking bench of the two-wire master against a slave model
`default_nettype none
module i2c_master_baud_and_arbitration_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic       low_voltage_i = 1'b0, stretch = 1'b0, collide = 1'b0, meas = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, d, slv_byte;
    logic       scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o, s_scl_oe, s_sda_oe, slv_got;
    logic       prev_oe = 1'b0;
    wire        scl_w = !(scl_oe_o | s_scl_oe);
    wire        sda_w = !(sda_oe_o | s_sda_oe);
    int         err_total = 0, check_count = 0, hc = 0, r, i, k;
    logic [31:0] seed = 32'h3790bbb5;
    logic [7:0] sent_q[$];
    int         half_q[$];
    logic [7:0] ra [5] = '{8'h8d, 8'h14, 8'h94, 8'h93, 8'h55};
    always #2 clk_i = ~clk_i;
    i2c_master_baud_arb uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .low_voltage_i(low_voltage_i), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .irq_o(irq_o));
    i2c_slave_model slv (.clk_i(clk_i), .scl_w_i(scl_w), .sda_w_i(sda_w),
        .stretch_i(stretch), .collide_i(collide), .scl_oe_o(s_scl_oe),
        .sda_oe_o(s_sda_oe), .got_o(slv_got), .byte_o(slv_byte));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= v;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    // poll a sticky event bit with a bound, then clear it
    task automatic wait_ev(input int b);
        d = 8'h00;
        for (k = 0; k < 3000 && d[b] !== 1'b1; k++) rd(8'h0d);
        if (d[b] !== 1'b1) begin
            err_total++;
            tally_and_finish;
        end
        wr(8'h0e, 8'h01 << b);
    endtask
    task automatic pulse_lv(input logic [7:0] e);
        @(posedge clk_i);
        low_voltage_i <= 1'b1;
        @(posedge clk_i);
        low_voltage_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk({7'h0, irq_o}, e);
        wr(8'h0e, 8'h80);
    endtask
    // low-half lengths of the master clock and bytes seen by the slave
    always @(posedge clk_i) begin
        prev_oe <= scl_oe_o;
        hc <= (scl_oe_o != prev_oe) ? 1 : hc + 1;
        if (meas && prev_oe && !scl_oe_o) half_q.push_back(hc);
        if (slv_got) chk(slv_byte, sent_q.pop_front());
    end
    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        foreach (ra[j]) begin
            rd(ra[j]);
            chk(d, 8'h00);
        end
        wr(8'h8d, 8'hff);
        rd(8'h8d);
        chk(d, 8'h88);
        pulse_lv(8'h01);
        wr(8'h8d, 8'h08);
        pulse_lv(8'h00);
        seed = lfsr(seed);
        r = 1 + seed[1:0] % 3;
        wr(8'h93, 8'h80 | 8'(r)); // top bit set, must not reach the reload
        // master mode and enable before any request
        wr(8'h14, 8'h68);
        // bus idle, claim it; the buffer write lands mid-start
        wr(8'h91, 8'h01);
        wr(8'h13, 8'h5a);
        rd(8'h14);
        chk(d, 8'he8);
        wr(8'h14, 8'h68);
        wait_ev(0);
        rd(8'h94);
        chk(d & 8'h0a, 8'h0a);
        // second byte stretched by the slave
        for (i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            sent_q.push_back(seed[7:0]);
            meas <= (i == 0);
            stretch <= (i == 1);
            wr(8'h13, seed[7:0]);
            repeat (60) @(posedge clk_i);
            stretch <= 1'b0;
            wait_ev(0);
            rd(8'h94);
            chk(d & 8'h04, 8'h00);
        end
        for (i = 1; i < 8; i++) chk(8'(half_q[i]), 8'(2 * (r + 1)));
        // receive a released byte, acknowledge it, then restart on the owned bus
        sent_q.push_back(8'hff);
        wr(8'h91, 8'h08);
        wait_ev(0);
        rd(8'h13);
        chk(d, 8'hff);
        wr(8'h91, 8'h10);
        wait_ev(0);
        wr(8'h91, 8'h02);
        wait_ev(0);
        rd(8'h94);
        chk(d & 8'h0a, 8'h0a);
        chk({7'h0, scl_oe_o}, 8'h01);
        wr(8'h91, 8'h04);
        wait_ev(0);
        // the stop seen a few clocks later sets the port event again
        repeat (8) @(posedge clk_i);
        rd(8'h0d);
        chk(d & 8'h01, 8'h01);
        wr(8'h0e, 8'h01);
        rd(8'h94);
        chk(d & 8'h12, 8'h10);
        wr(8'h14, 8'h00);
        rd(8'h94);
        chk(d & 8'h18, 8'h00);
        wr(8'h14, 8'h28);
        wr(8'h91, 8'h01);
        wait_ev(0);
        collide <= 1'b1;
        wr(8'h13, 8'hff);
        #1;
        for (k = 0; k < 300 && irq_o !== 1'b1; k++) #4;
        chk({4'h0, scl_o, sda_o, scl_oe_o, sda_oe_o}, 8'h00);
        chk({7'h0, irq_o}, 8'h01);
        rd(8'h0d);
        chk(d & 8'h08, 8'h08);
        collide <= 1'b0;
        wr(8'h0e, 8'h08);
        chk(8'(sent_q.size()), 8'h00);
        tally_and_finish;
    end
endmodule
`default_nettype wire
